// ===== rtl/eprom_program_control_boot.sv
`default_nettype none
module eprom_program_control_boot
    import eprom_prog_pkg::*;
#(
    parameter int PULSE_COUNT = PULSE_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire cpu_bus_type cpu,
    input  wire logic        test_level_voltage,
    input  wire logic        boot_select_pin,
    input  wire logic [7:0]  array_rdata,
    input  wire logic [7:0]  boot_rom_rdata,
    output var  logic [7:0]  rdata,
    output var  logic        rdata_valid,
    output var  logic        boot_mode,
    output var  logic        array_read_en,
    output var  logic [15:0] array_addr,
    output var  logic [7:0]  array_wdata,
    output var  logic        array_loaded,
    output var  logic        program_power_enable,
    output var  logic        address_data_latch_enable,
    output var  logic        pulse_done
);

    typedef struct packed {
        logic [1:0]      sync1;
        logic [1:0]      sync2;
        logic [1:0]      sync3;
        strap_state_type strap;
        logic            boot;
        logic            latch_en;
        logic            power_en;
        logic            rd_en;
        prog_latch_type  plat;
        logic [7:0]      rdata;
        logic            rvalid;
    } top_state_type;

    top_state_type s_q;
    top_state_type s_d;
    logic          in_eprom;
    logic          in_boot;
    logic          in_ctrl;
    logic          timer_done;

    pulse_timer #(
        .COUNT (PULSE_COUNT)
    ) u_pulse_timer (
        .core_clk (core_clk),
        .nrst     (nrst),
        .run      (s_q.power_en),
        .done     (timer_done)
    );

    always_comb begin
        in_eprom = (cpu.addr >= EPROM_LO) && (cpu.addr <= EPROM_HI);
        in_boot  = s_q.boot && (cpu.addr >= BOOT_LO) && (cpu.addr <= BOOT_HI);
        in_ctrl  = (cpu.addr == CTRL_ADDR);
    end

    always_comb begin
        s_d        = s_q;
        s_d.sync1  = {test_level_voltage, boot_select_pin};
        s_d.sync2  = s_q.sync1;
        s_d.sync3  = s_q.sync2;
        s_d.rvalid = 1'b0;

        // strap sampled once the chain holds post-reset pin levels
        unique case (s_q.strap)
            st_fill0: s_d.strap = st_fill1;
            st_fill1: s_d.strap = st_check;
            st_check: begin
                if (s_q.sync2 == s_q.sync3) begin
                    s_d.boot  = &s_q.sync3;
                    s_d.strap = st_done;
                end
            end
            st_done:  s_d.strap = st_done;
        endcase

        // control register write
        if (cpu.wr && in_ctrl) begin
            s_d.latch_en = cpu.wdata[LATCH_BIT];
            s_d.power_en = cpu.wdata[POWER_BIT] & cpu.wdata[LATCH_BIT];
        end else begin
            s_d.power_en = s_q.power_en & s_q.latch_en;
        end
        s_d.rd_en = !s_d.latch_en;

        // eprom writes only land in the latches while latch enable is set
        if (cpu.wr && in_eprom && s_q.latch_en) begin
            s_d.plat.addr   = cpu.addr;
            s_d.plat.data   = cpu.wdata;
            s_d.plat.loaded = 1'b1;
        end else if (!s_q.latch_en) begin
            s_d.plat.loaded = 1'b0;
        end

        // read mux
        if (cpu.rd) begin
            s_d.rvalid = 1'b1;
            if (in_ctrl) begin
                s_d.rdata = {6'h00, s_q.latch_en, s_q.power_en};
            end else if (in_eprom) begin
                s_d.rdata = s_q.latch_en ? READ_BLANK : array_rdata;
            end else if (in_boot) begin
                s_d.rdata = boot_rom_rdata;
            end else begin
                s_d.rdata = READ_BLANK;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q          <= '0;
            s_q.strap    <= st_fill0;
            s_q.latch_en <= CTRL_RESET[LATCH_BIT];
            s_q.power_en <= CTRL_RESET[POWER_BIT];
            s_q.rd_en    <= !CTRL_RESET[LATCH_BIT];
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        rdata                     = s_q.rdata;
        rdata_valid               = s_q.rvalid;
        boot_mode                 = s_q.boot;
        array_read_en             = s_q.rd_en;
        array_addr                = s_q.plat.addr;
        array_wdata               = s_q.plat.data;
        array_loaded              = s_q.plat.loaded;
        program_power_enable      = s_q.power_en;
        address_data_latch_enable = s_q.latch_en;
        pulse_done                = timer_done;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_power_needs_latch: assert property (s_q.power_en |-> s_q.latch_en)
        else $error("program power on without latch enable");

    a_ctrl_read_value: assert property (cpu.rd && in_ctrl |=>
        rdata_valid && rdata == {6'h00, $past(s_q.latch_en), $past(s_q.power_en)})
        else $error("control register read value wrong");

    a_reserved_bits_zero: assert property (cpu.rd && in_ctrl |=> rdata[7:2] == 6'h00)
        else $error("reserved bits read nonzero");

    a_ctrl_write_latch: assert property (cpu.wr && in_ctrl |=>
        s_q.latch_en == $past(cpu.wdata[LATCH_BIT]))
        else $error("latch enable did not take written value");

    a_eprom_blank_latched: assert property (cpu.rd && in_eprom && s_q.latch_en |=>
        rdata == READ_BLANK)
        else $error("array contents visible while latched");

    a_eprom_normal_read: assert property (cpu.rd && in_eprom && !s_q.latch_en |=>
        rdata == $past(array_rdata))
        else $error("normal eprom read data wrong");

    a_write_captured: assert property (cpu.wr && in_eprom && s_q.latch_en |=>
        array_loaded && array_addr == $past(cpu.addr) && array_wdata == $past(cpu.wdata))
        else $error("eprom write not captured in latches");

    a_unlatched_write_ignored: assert property (cpu.wr && in_eprom && !s_q.latch_en |=>
        !array_loaded)
        else $error("write captured without latch enable");

    a_boot_rom_read: assert property (cpu.rd && in_boot |=> rdata == $past(boot_rom_rdata))
        else $error("boot rom read data wrong");

    a_strap_stable: assert property (s_q.strap == st_done |=> $stable(s_q.boot))
        else $error("boot mode changed after capture");

    a_pulse_timing: assert property ($rose(s_q.power_en) |-> !pulse_done [*3])
        else $error("pulse done too early");

    a_power_write_forced: assert property (cpu.wr && in_ctrl |=>
        program_power_enable == ($past(cpu.wdata[POWER_BIT]) && $past(cpu.wdata[LATCH_BIT])))
        else $error("program power not forced by latch enable");

    a_read_valid_set: assert property (cpu.rd |=> rdata_valid)
        else $error("read data valid missing");

    a_read_valid_clear: assert property (!cpu.rd |=> !rdata_valid)
        else $error("read data valid without read");

    a_read_en_follows: assert property (cpu.wr && in_ctrl |=>
        array_read_en == !$past(cpu.wdata[LATCH_BIT]))
        else $error("array read enable does not follow latch enable");

    a_loaded_clears: assert property (!s_q.latch_en |=> !array_loaded)
        else $error("latches hold a write without latch enable");

    a_unmapped_blank: assert property (cpu.rd && !in_ctrl && !in_eprom && !in_boot |=>
        rdata == READ_BLANK)
        else $error("unmapped read not blank");

    a_boot_captured: assert property (s_q.strap == st_check && s_q.sync2 == s_q.sync3 |=>
        boot_mode == $past(&s_q.sync3))
        else $error("boot mode not taken from strap pins");

endmodule
`default_nettype wire

// ===== rtl/eprom_prog_pkg.sv
`default_nettype none
package eprom_prog_pkg;

    // register map
    localparam logic [15:0] CTRL_ADDR       = 16'h0026;
    localparam int          LATCH_BIT       = 1;
    localparam int          POWER_BIT       = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // memory ranges
    localparam logic [15:0] BOOT_LO         = 16'hfe00;
    localparam logic [15:0] BOOT_HI         = 16'hffef;
    localparam int          EPROM_BYTES     = 48640;
    localparam logic [15:0] EPROM_LO        = 16'h4000;
    localparam logic [15:0] EPROM_HI        = 16'hfdff;
    localparam logic [7:0]  READ_BLANK      = 8'h00;

    // program pulse timing
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          PULSE_TIME_NS   = 1000000;
    localparam int          PULSE_CYCLES    = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PULSE_CNT_W     = 16;

    // strap capture after reset release
    typedef enum logic [1:0] {
        st_fill0 = 2'b00,
        st_fill1 = 2'b01,
        st_check = 2'b11,
        st_done  = 2'b10
    } strap_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } cpu_bus_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        loaded;
    } prog_latch_type;

endpackage
`default_nettype wire

// ===== rtl/pulse_timer.sv
`default_nettype none
module pulse_timer
    import eprom_prog_pkg::*;
#(
    parameter int COUNT = PULSE_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic run,
    output var  logic done
);

    typedef struct packed {
        logic [PULSE_CNT_W-1:0] cnt;
        logic                   done;
    } timer_state_type;

    localparam logic [PULSE_CNT_W-1:0] LAST = PULSE_CNT_W'(COUNT - 1);

    timer_state_type s_q;
    timer_state_type s_d;

    // counts while power is on, restarts when it drops
    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d.cnt  = '0;
            s_d.done = 1'b0;
        end else if (!s_q.done) begin
            if (s_q.cnt == LAST) begin
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;

endmodule
`default_nettype wire

// ===== tb/ext_eprom_model.sv
`default_nettype none
module ext_eprom_model (
    input  wire logic [15:0] addr,
    output var  logic [7:0]  data
);
    timeunit 1ns;
    timeprecision 1ns;
    // external eprom image, one byte per on-chip address
    always_comb data = addr[7:0] ^ addr[15:8] ^ 8'h5a;
endmodule
`default_nettype wire

// ===== tb/eprom_program_control_boot_tb_top.sv
`default_nettype none
module eprom_program_control_boot_tb_top import eprom_prog_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 8;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    cpu_bus_type cpu = '0;
    logic        test_level_voltage = 1'b0;
    logic        boot_select_pin = 1'b0;
    logic [7:0]  array_rdata = 8'h00;
    logic [7:0]  boot_rom_rdata = 8'h00;
    logic [7:0]  rdata, array_wdata, ext_data, ctl_m;
    logic [15:0] array_addr, ext_addr, a;
    logic        rdata_valid, boot_mode, array_read_en, array_loaded;
    logic        program_power_enable, address_data_latch_enable, pulse_done;
    logic [15:0] tbl [6] = '{EPROM_LO, EPROM_HI, BOOT_LO, BOOT_HI, 16'hfff0, 16'h3fff};
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          cnt;

    eprom_program_control_boot #(.PULSE_COUNT(PC)) eprom_program_control_boot_inst (
        .core_clk, .nrst, .cpu, .test_level_voltage, .boot_select_pin, .array_rdata,
        .boot_rom_rdata, .rdata, .rdata_valid, .boot_mode, .array_read_en, .array_addr,
        .array_wdata, .array_loaded, .program_power_enable, .address_data_latch_enable,
        .pulse_done
    );
    ext_eprom_model ext_eprom_model_inst (.addr(ext_addr), .data(ext_data));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_rd(input logic [15:0] ad, input logic bm);
        if (ad == 16'h0026) return ctl_m;
        if (ad >= 16'h4000 && ad <= 16'hfdff) return ctl_m[1] ? 8'h00 : array_rdata;
        if (ad >= 16'hfe00 && ad <= 16'hffef && bm) return boot_rom_rdata;
        return 8'h00;
    endfunction

    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        cpu <= {ad, d, 1'b1, 1'b0};
        @(posedge core_clk);
        cpu.wr <= 1'b0;
        if (ad == 16'h0026) begin
            ctl_m = d & 8'h03;
            ctl_m[0] = ctl_m[0] & ctl_m[1];
        end
        #1;
    endtask

    task automatic rd(input logic [15:0] ad, input logic bm);
        @(posedge core_clk);
        array_rdata <= 8'($urandom);
        boot_rom_rdata <= 8'($urandom);
        cpu <= {ad, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        cpu.rd <= 1'b0;
        #1;
        chk(16'(rdata_valid), 16'h1);
        chk(16'(rdata), 16'(exp_rd(ad, bm)));
    endtask

    initial begin
        void'($urandom(32'ha741));
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            nrst <= 1'b0;
            test_level_voltage <= s[0];
            boot_select_pin <= s[1];
            repeat (16) @(posedge core_clk);
            nrst <= 1'b1;
            repeat (5) @(posedge core_clk);
            #1;
            ctl_m = 8'h00;
            chk(16'(boot_mode), 16'(s == 3));
            rd(16'h0026, s == 3);
            for (int i = 0; i < 8; i++) begin
                a = (i < 6) ? tbl[i] : 16'($urandom);
                rd(a, s == 3);
            end
            $display("strap case %0d done", s);
        end
        for (int i = 0; i < 7; i++) begin
            wr(16'h0026, (i < 6) ? (tbl[i][7:0] | 8'hfc) : 8'hfd);
            chk(16'({address_data_latch_enable, program_power_enable}), 16'(ctl_m[1:0]));
            rd(16'h0026, 1'b1);
        end
        $display("control register done");
        for (int n = 0; n < 4; n++) begin
            ext_addr = EPROM_LO + 16'($urandom_range(EPROM_BYTES - 1));
            #1;
            wr(16'h0026, 8'h02);
            wr(ext_addr, ext_data);
            chk(array_addr, ext_addr);
            chk(16'(array_wdata), 16'(ext_data));
            chk(16'({array_loaded, array_read_en}), 16'h2);
            rd(ext_addr, 1'b1);
            wr(16'h0026, 8'h03);
            cnt = 0;
            while (pulse_done !== 1'b1 && cnt < 40) begin
                @(posedge core_clk);
                #1;
                cnt++;
            end
            chk(16'(cnt), 16'(PC));
            wr(16'h0026, 8'h02);
            chk(16'(program_power_enable), 16'h0);
            wr(16'h0026, 8'h00);
            chk(16'({pulse_done, array_read_en}), 16'h1);
            wr(ext_addr, ~ext_data);
            chk(16'(array_loaded), 16'h0);
        end
        $display("programming done");
        complete_run();
    end
endmodule
`default_nettype wire
